//--- rtl/burst_if.sv
// Burst start request and busy status between decoder and tracker
`timescale 1ns/10ps
interface burst_if;
  logic start;
  logic is_write;
  logic full;
  logic busy;
  logic done;
  modport decoder (output start, output is_write, output full, input busy, input done);
  modport tracker (input start, input is_write, input full, output busy, output done);
endinterface

//--- rtl/burst_tracker.sv
// Tracks a running burst until its last beat
`timescale 1ns/10ps
`include "cmd_decoder_defines.svh"
module burst_tracker
  import cmd_decoder_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Decoder side
  burst_if.tracker bif
);
  typedef struct packed {
    burst_state_t state;
    logic [3:0] beats;
    logic done;
  } track_t;
  track_t cur;
  track_t next_cur;

  always_comb
  begin
    next_cur = cur;
    next_cur.done = 1'b0;
    case (cur.state)
      BURST_IDLE:
      begin
        if (bif.start)
        begin
          next_cur.state = bif.is_write ? BURST_WRITE : BURST_READ;
          next_cur.beats = bif.full ? `BURST_FULL : `BURST_CHOP;
        end
      end
      BURST_WRITE, BURST_READ:
      begin
        if (cur.beats <= `BEAT_STEP)
        begin
          next_cur.state = BURST_IDLE;
          next_cur.beats = `BEAT_ZERO;
          next_cur.done = 1'b1;
        end
        else
        begin
          next_cur.beats = cur.beats - `BEAT_STEP;
        end
      end
      default:
      begin
        next_cur.state = BURST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur <= '{state: BURST_IDLE, beats: `BEAT_ZERO, done: 1'b0};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign bif.busy = (cur.state != BURST_IDLE);
  assign bif.done = cur.done;
endmodule // burst_tracker

//--- rtl/cmd_decoder_defines.svh
// Constants for the command decoder
// Notes on behaviour
// - Command taken from strobes at rising edge
// - All strobes low: mode set command
// - Write strobe high only: periodic refresh
// - Close pattern, flag low: close one bank
// - Close pattern, flag high: close all banks
// - Row open on selected bank with row
// - Write burst at column; top bit reserved
// - Read burst at column in selected bank
// - Chop bit low four, high eight
// - Write with flag high closes row after
// - Read with flag high closes row after
// - Idle pattern starts no operation
// - Chip select high ignores all inputs except the clock gate
// - Gate falling with idle: low power entry
// - Gate rising with idle: low power exit
// - Calibration pattern flag high: long calibration
// - Calibration pattern flag low: short calibration
// - Bank, row, column widths set by defines
// - Reset is asynchronous and active low
// - Bank select picks one of four mode registers
// - Running burst never cut by later command
// - Idle never alters an operation in progress
`ifndef CMD_DECODER_DEFINES_SVH
`define CMD_DECODER_DEFINES_SVH
`define BANK_W 3
`define ADDR_W 16
`define ROW_W 16
`define COL_W 10
`define FLAG_BIT 10
`define CHOP_BIT 12
`define MODE_SEL_W 2
`define BURST_FULL 4'h8
`define BURST_CHOP 4'h4
`define BEAT_STEP 4'h2
`define BEAT_ZERO 4'h0
`define DEFAULT_FULL 1'b1
`define STROBES_MODE 3'h0
`define STROBES_REFRESH 3'h1
`define STROBES_CLOSE 3'h2
`define STROBES_OPEN 3'h3
`define STROBES_WRITE 3'h4
`define STROBES_READ 3'h5
`define STROBES_CAL 3'h6
`define STROBES_IDLE 3'h7
`endif

//--- rtl/cmd_decoder_pkg.sv
// Types shared by the command decoder files
package cmd_decoder_pkg;
  typedef enum logic [4:0] {
    CMD_NONE = 5'h00,
    CMD_MODE_SET = 5'h01,
    CMD_REFRESH = 5'h02,
    CMD_SELF_ENTRY = 5'h03,
    CMD_SELF_EXIT = 5'h04,
    CMD_CLOSE_ONE = 5'h05,
    CMD_CLOSE_ALL = 5'h06,
    CMD_OPEN = 5'h07,
    CMD_WRITE = 5'h08,
    CMD_READ = 5'h09,
    CMD_IDLE = 5'h0A,
    CMD_UNSELECTED = 5'h0B,
    CMD_LP_ENTRY = 5'h0C,
    CMD_LP_EXIT = 5'h0D,
    CMD_CAL_LONG = 5'h0E,
    CMD_CAL_SHORT = 5'h0F,
    CMD_RESERVED = 5'h10
  } cmd_t;
  typedef enum logic [1:0] {
    BURST_IDLE = 2'b00,
    BURST_WRITE = 2'b01,
    BURST_READ = 2'b10
  } burst_state_t;
endpackage

//--- rtl/sdram_command_decoder.sv
// Command decoder of the memory device
`timescale 1ns/10ps
`include "cmd_decoder_defines.svh"
module sdram_command_decoder
  import cmd_decoder_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // Command pins
  input wire logic CHIP_SELECT_N,
  input wire logic ROW_STROBE_N,
  input wire logic COLUMN_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic CLOCK_GATE,
  input wire logic [`BANK_W-1:0] BANK_SELECT,
  input wire logic [`ADDR_W-1:0] ADDR,
  // Burst length fixed at full (eight beats) when low
  input wire logic PER_COMMAND_SELECT,
  // Decoded command
  output logic [4:0] CMD_CODE,
  output logic CMD_VALID,
  output logic [`BANK_W-1:0] CMD_BANK,
  output logic [`ROW_W-1:0] ROW_ADDR,
  output logic [`COL_W-1:0] COL_ADDR,
  output logic [`MODE_SEL_W-1:0] MODE_REG_SEL,
  output logic [`ADDR_W-1:0] MODE_OPCODE,
  output logic AUTO_CLOSE,
  output logic FULL_BURST,
  // Device status
  output logic BURST_BUSY,
  output logic BURST_DONE,
  output logic SELF_RECHARGE,
  output logic LOW_POWER,
  output logic OPEN_BANKS_ANY
);
  typedef struct packed {
    logic gate_prev;
    cmd_t cmd;
    logic valid;
    logic [`BANK_W-1:0] bank;
    logic [`ROW_W-1:0] row;
    logic [`COL_W-1:0] col;
    logic [`MODE_SEL_W-1:0] mode_sel;
    logic [`ADDR_W-1:0] opcode;
    logic auto_close;
    logic full;
    logic self_rech;
    logic low_power;
    logic [(1<<`BANK_W)-1:0] open_banks;
    logic close_pend;
    logic [`BANK_W-1:0] close_bank;
  } dec_t;
  dec_t cur;
  dec_t next_cur;
  cmd_t decoded;
  logic [3:0] strobes;
  logic gate_hold;
  logic idle_pins;
  logic [(1<<`BANK_W)-1:0] bank_bit;

  burst_if bif ();

  burst_tracker u_tracker (
    .clk(MCLK),
    .rst_n(RSTN),
    .bif(bif)
  );

  // Per bank decode of the selected bank
  genvar gi;
  generate
    for (gi = 0; gi < (1<<`BANK_W); gi++)
    begin : g_bank
      assign bank_bit[gi] = (BANK_SELECT == `BANK_W'(gi));
    end
  endgenerate

  assign strobes = {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_STROBE_N, CHIP_SELECT_N};
  assign gate_hold = cur.gate_prev && CLOCK_GATE;
  assign idle_pins = strobes[0] || (strobes[3:1] == `STROBES_IDLE);

  always_comb
  begin
    decoded = CMD_RESERVED;
    if (cur.self_rech || cur.low_power)
    begin
      if (!cur.gate_prev && CLOCK_GATE && idle_pins)
        decoded = cur.self_rech ? CMD_SELF_EXIT : CMD_LP_EXIT;
      else
        decoded = CMD_NONE;
    end
    else if (gate_hold)
    begin
      if (CHIP_SELECT_N)
        decoded = CMD_UNSELECTED;
      else
      begin
        case (strobes[3:1])
          `STROBES_MODE: decoded = CMD_MODE_SET;
          `STROBES_REFRESH: decoded = CMD_REFRESH;
          `STROBES_CLOSE: decoded = ADDR[`FLAG_BIT] ? CMD_CLOSE_ALL : CMD_CLOSE_ONE;
          `STROBES_OPEN: decoded = CMD_OPEN;
          `STROBES_WRITE: decoded = CMD_WRITE;
          `STROBES_READ: decoded = CMD_READ;
          `STROBES_CAL: decoded = ADDR[`FLAG_BIT] ? CMD_CAL_LONG : CMD_CAL_SHORT;
          `STROBES_IDLE: decoded = CMD_IDLE;
          default: decoded = CMD_RESERVED;
        endcase
      end
    end
    else if (cur.gate_prev && !CLOCK_GATE)
    begin
      if (!CHIP_SELECT_N && strobes[3:1] == `STROBES_REFRESH)
        decoded = CMD_SELF_ENTRY;
      else if (idle_pins)
        decoded = CMD_LP_ENTRY;
    end
  end

  always_comb
  begin
    next_cur = cur;
    next_cur.gate_prev = CLOCK_GATE;
    next_cur.cmd = decoded;
    next_cur.valid = (decoded != CMD_NONE) && (decoded != CMD_RESERVED)
      && (decoded != CMD_IDLE) && (decoded != CMD_UNSELECTED);
    if (bif.done && cur.close_pend)
    begin
      next_cur.open_banks[cur.close_bank] = 1'b0;
      next_cur.close_pend = 1'b0;
    end
    case (decoded)
      CMD_MODE_SET:
      begin
        next_cur.mode_sel = BANK_SELECT[`MODE_SEL_W-1:0];
        next_cur.opcode = ADDR;
      end
      CMD_SELF_ENTRY: next_cur.self_rech = 1'b1;
      CMD_SELF_EXIT: next_cur.self_rech = 1'b0;
      CMD_LP_ENTRY: next_cur.low_power = 1'b1;
      CMD_LP_EXIT: next_cur.low_power = 1'b0;
      CMD_CLOSE_ONE: next_cur.open_banks = next_cur.open_banks & ~bank_bit;
      CMD_CLOSE_ALL: next_cur.open_banks = '0;
      CMD_OPEN:
      begin
        next_cur.bank = BANK_SELECT;
        next_cur.row = ADDR[`ROW_W-1:0];
        next_cur.open_banks = next_cur.open_banks | bank_bit;
      end
      CMD_WRITE, CMD_READ:
      begin
        if (!bif.busy)
        begin
          next_cur.bank = BANK_SELECT;
          next_cur.col = ADDR[`COL_W-1:0];
          next_cur.auto_close = ADDR[`FLAG_BIT];
          next_cur.full = PER_COMMAND_SELECT ? ADDR[`CHOP_BIT] : `DEFAULT_FULL;
          next_cur.close_pend = ADDR[`FLAG_BIT];
          next_cur.close_bank = BANK_SELECT;
        end
        else
        begin
          next_cur.valid = 1'b0;
        end
      end
      default:
      begin
        next_cur.valid = next_cur.valid;
      end
    endcase
  end

  assign bif.start = (decoded == CMD_WRITE || decoded == CMD_READ) && !bif.busy;
  assign bif.is_write = (decoded == CMD_WRITE);
  assign bif.full = PER_COMMAND_SELECT ? ADDR[`CHOP_BIT] : `DEFAULT_FULL;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      cur <= '{cmd: CMD_NONE, default: '0};
    else
      cur <= next_cur;
  end

  assign CMD_CODE = cur.cmd;
  assign CMD_VALID = cur.valid;
  assign CMD_BANK = cur.bank;
  assign ROW_ADDR = cur.row;
  assign COL_ADDR = cur.col;
  assign MODE_REG_SEL = cur.mode_sel;
  assign MODE_OPCODE = cur.opcode;
  assign AUTO_CLOSE = cur.auto_close;
  assign FULL_BURST = cur.full;
  assign BURST_BUSY = bif.busy;
  assign BURST_DONE = bif.done;
  assign SELF_RECHARGE = cur.self_rech;
  assign LOW_POWER = cur.low_power;
  assign OPEN_BANKS_ANY = |cur.open_banks;
endmodule // sdram_command_decoder

//--- sim/cmd_decoder_chk_sva.sv
// Port checker for the command decoder
`timescale 1ns/10ps
`include "cmd_decoder_defines.svh"
module cmd_decoder_chk
  import cmd_decoder_pkg::*;
(
  // Clock, reset and pins
  input wire logic MCLK, RSTN, CHIP_SELECT_N, ROW_STROBE_N, COLUMN_STROBE_N,
  input wire logic WRITE_STROBE_N, CLOCK_GATE, PER_COMMAND_SELECT,
  input wire logic [`BANK_W-1:0] BANK_SELECT,
  input wire logic [`ADDR_W-1:0] ADDR,
  // Decoded outputs
  input wire logic [4:0] CMD_CODE,
  input wire logic CMD_VALID, AUTO_CLOSE, FULL_BURST, BURST_BUSY, BURST_DONE,
  input wire logic SELF_RECHARGE, LOW_POWER,
  input wire logic [`ROW_W-1:0] ROW_ADDR,
  input wire logic [`COL_W-1:0] COL_ADDR,
  input wire logic [`MODE_SEL_W-1:0] MODE_REG_SEL
);
  logic gate_q;
  logic [3:0] p;
  logic norm;
  logic quiet;
  logic rw;
  assign p = {CHIP_SELECT_N, ROW_STROBE_N, COLUMN_STROBE_N, WRITE_STROBE_N};
  assign quiet = p[3] || p == 4'h7;
  assign rw = p == 4'h4 || p == 4'h5;
  assign norm = gate_q && CLOCK_GATE && !LOW_POWER && !SELF_RECHARGE;
  always_ff @(posedge MCLK or negedge RSTN)
    if (!RSTN)
      gate_q <= 1'b0;
    else
      gate_q <= CLOCK_GATE;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);
  AST_MODE: assert property (norm && p == 4'h0 |=> CMD_CODE == CMD_MODE_SET
    && MODE_REG_SEL == $past(BANK_SELECT[1:0])) else $error("mode set wrong");
  AST_RDWR: assert property (norm && rw && !BURST_BUSY |=> CMD_VALID
    && COL_ADDR == $past(ADDR[9:0]) && AUTO_CLOSE == $past(ADDR[10])
    && FULL_BURST == $past(!PER_COMMAND_SELECT || ADDR[12])) else $error("burst wrong");
  AST_KEEP: assert property (norm && rw && BURST_BUSY && !BURST_DONE |=>
    !CMD_VALID && $stable(COL_ADDR)) else $error("burst cut");
  AST_FULL: assert property ($rose(BURST_BUSY) && FULL_BURST |->
    (BURST_BUSY && !BURST_DONE)[*4] ##1 (BURST_DONE && !BURST_BUSY)) else $error("full length");
  AST_CHOP: assert property ($rose(BURST_BUSY) && !FULL_BURST |->
    (BURST_BUSY && !BURST_DONE)[*2] ##1 (BURST_DONE && !BURST_BUSY)) else $error("chop length");
  AST_OPEN: assert property (norm && p == 4'h3 |=> CMD_CODE == CMD_OPEN
    && ROW_ADDR == $past(ADDR)) else $error("open wrong");
  AST_CAL: assert property (norm && p == 4'h6 |=> CMD_CODE ==
    ($past(ADDR[10]) ? CMD_CAL_LONG : CMD_CAL_SHORT)) else $error("cal wrong");
  AST_QUIET: assert property (norm && quiet |=> !CMD_VALID
    && $stable(ROW_ADDR)) else $error("idle acted");
  AST_LP: assert property (gate_q && !CLOCK_GATE && !LOW_POWER && !SELF_RECHARGE
    && quiet |=> LOW_POWER) else $error("no low power");
  AST_WAKE: assert property (!gate_q && CLOCK_GATE && quiet
    |=> !LOW_POWER && !SELF_RECHARGE) else $error("no wake");
  cover property (BURST_DONE);
  cover property ($rose(LOW_POWER));
  cover property ($rose(SELF_RECHARGE));
endmodule // cmd_decoder_chk
bind sdram_command_decoder cmd_decoder_chk i_cmd_decoder_chk (.MCLK, .RSTN,
  .CHIP_SELECT_N, .ROW_STROBE_N, .COLUMN_STROBE_N, .WRITE_STROBE_N, .CLOCK_GATE,
  .PER_COMMAND_SELECT, .BANK_SELECT, .ADDR, .CMD_CODE, .CMD_VALID, .AUTO_CLOSE,
  .FULL_BURST, .BURST_BUSY, .BURST_DONE, .SELF_RECHARGE, .LOW_POWER, .ROW_ADDR,
  .COL_ADDR, .MODE_REG_SEL);

//--- sim/ddr_ctrl_model.sv
// Controller model driving command and address pins
`timescale 1ns/10ps
module ddr_ctrl_model (
  // Clock
  input wire logic clk,
  // Command pins
  output logic cs_n, ras_n, cas_n, we_n, cke,
  output logic [2:0] ba,
  output logic [15:0] a
);
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    cke = 1'b0;
    ba = 3'h0;
    a = 16'h0;
  end
  task automatic issue(input logic [3:0] p, input logic g, input logic [2:0] b,
                       input logic [15:0] ad);
    @(posedge clk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = p;
    cke = g;
    // Unused lines toggle so stale values never help
    ba = (p[3] || p == 4'h7) ? ~ba : b;
    a = (p[3] || p == 4'h7) ? ~a : ad;
  endtask
endmodule // ddr_ctrl_model

//--- sim/sdram_command_decoder_bench.sv
// Self-checking bench for the command decoder
`timescale 1ns/10ps
module sdram_command_decoder_bench
  import cmd_decoder_pkg::*;
;
  logic mclk, rstn, pcs, cs_n, ras_n, cas_n, we_n, cke, valid, aclose, full;
  logic busy, done, selfr, lowp, anyo;
  logic [2:0] ba, bank;
  logic [15:0] a, row, opc;
  logic [4:0] code;
  logic [9:0] col;
  logic [1:0] msel;
  int n_errors, checks_done, cycles;
  ddr_ctrl_model i_ddr_ctrl_model (.clk(mclk), .cs_n, .ras_n, .cas_n, .we_n, .cke,
    .ba, .a);
  sdram_command_decoder i_sdram_command_decoder (.MCLK(mclk), .RSTN(rstn),
    .CHIP_SELECT_N(cs_n), .ROW_STROBE_N(ras_n), .COLUMN_STROBE_N(cas_n),
    .WRITE_STROBE_N(we_n), .CLOCK_GATE(cke), .BANK_SELECT(ba), .ADDR(a),
    .PER_COMMAND_SELECT(pcs), .CMD_CODE(code), .CMD_VALID(valid), .CMD_BANK(bank),
    .ROW_ADDR(row), .COL_ADDR(col), .MODE_REG_SEL(msel), .MODE_OPCODE(opc),
    .AUTO_CLOSE(aclose), .FULL_BURST(full), .BURST_BUSY(busy), .BURST_DONE(done),
    .SELF_RECHARGE(selfr), .LOW_POWER(lowp), .OPEN_BANKS_ANY(anyo));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Command, then deselect while the answer is read
  task automatic op(input logic [3:0] p, input logic g, input logic [2:0] b,
                    input logic [15:0] ad);
    i_ddr_ctrl_model.issue(p, g, b, ad);
    i_ddr_ctrl_model.issue(4'h8, g, 3'h0, 16'h0);
  endtask
  task automatic ck(input cmd_t c, input logic v);
    chk("code", 16'(c), 16'(code));
    chk("valid", 16'(v), 16'(valid));
  endtask
  task automatic t_mode();
    for (int b = 0; b < 4; b++)
    begin
      op(4'h0, 1'b1, 3'(b), 16'hA5C0 + 16'(b));
      ck(CMD_MODE_SET, 1'b1);
      chk("msel", 16'(b), 16'(msel));
      chk("opcode", 16'hA5C0 + 16'(b), opc);
    end
  endtask
  task automatic t_rows();
    op(4'h1, 1'b1, 3'h2, 16'h1234);
    ck(CMD_REFRESH, 1'b1);
    op(4'h3, 1'b1, 3'h3, 16'hFEDC);
    ck(CMD_OPEN, 1'b1);
    chk("row", 16'hFEDC, row);
    chk("bank", 16'h0003, 16'(bank));
    chk("open", 16'h0001, 16'(anyo));
    op(4'h2, 1'b1, 3'h5, 16'hFBFF);
    ck(CMD_CLOSE_ONE, 1'b1);
    op(4'h2, 1'b1, 3'h3, 16'h0400);
    ck(CMD_CLOSE_ALL, 1'b1);
    chk("open", 16'h0000, 16'(anyo));
    op(4'h6, 1'b1, 3'h7, 16'h0400);
    ck(CMD_CAL_LONG, 1'b1);
    op(4'h6, 1'b1, 3'h7, 16'hFBFF);
    ck(CMD_CAL_SHORT, 1'b1);
    op(4'h7, 1'b1, 3'h1, 16'h0000);
    ck(CMD_IDLE, 1'b0);
    op(4'hC, 1'b1, 3'h1, 16'h0000);
    ck(CMD_UNSELECTED, 1'b0);
    chk("row", 16'hFEDC, row);
  endtask
  task automatic t_burst();
    int n;
    pcs = 1'b1;
    op(4'h5, 1'b1, 3'h6, 16'h17FF);
    ck(CMD_READ, 1'b1);
    chk("col", 16'h03FF, 16'(col));
    chk("aclose", 16'h0001, 16'(aclose));
    chk("full", 16'h0001, 16'(full));
    op(4'h4, 1'b1, 3'h1, 16'h0000);
    ck(CMD_WRITE, 1'b0);
    chk("col", 16'h03FF, 16'(col));
    n = 0;
    while (done !== 1'b1 && n < 10)
    begin
      @(posedge mclk);
      #2;
      n++;
    end
    chk("done", 16'h0001, 16'(done));
    op(4'h4, 1'b1, 3'h2, 16'h0155);
    ck(CMD_WRITE, 1'b1);
    chk("full", 16'h0000, 16'(full));
    chk("aclose", 16'h0000, 16'(aclose));
    i_ddr_ctrl_model.issue(4'h8, 1'b1, 3'h0, 16'h0);
    chk("done", 16'h0000, 16'(done));
    chk("busy", 16'h0001, 16'(busy));
    i_ddr_ctrl_model.issue(4'h8, 1'b1, 3'h0, 16'h0);
    chk("done", 16'h0001, 16'(done));
    chk("busy", 16'h0000, 16'(busy));
    pcs = 1'b0;
    op(4'h4, 1'b1, 3'h2, 16'h0401);
    chk("full", 16'h0001, 16'(full));
    chk("aclose", 16'h0001, 16'(aclose));
  endtask
  task automatic t_power();
    repeat (5) i_ddr_ctrl_model.issue(4'h8, 1'b1, 3'h0, 16'h0);
    op(4'h7, 1'b0, 3'h0, 16'h0);
    ck(CMD_LP_ENTRY, 1'b1);
    chk("lowp", 16'h0001, 16'(lowp));
    op(4'h0, 1'b0, 3'h0, 16'h0);
    ck(CMD_NONE, 1'b0);
    op(4'h8, 1'b1, 3'h0, 16'h0);
    ck(CMD_LP_EXIT, 1'b1);
    op(4'h1, 1'b0, 3'h0, 16'h0);
    ck(CMD_SELF_ENTRY, 1'b1);
    chk("selfr", 16'h0001, 16'(selfr));
    op(4'h7, 1'b1, 3'h0, 16'h0);
    ck(CMD_SELF_EXIT, 1'b1);
    op(4'h5, 1'b0, 3'h0, 16'h0);
    ck(CMD_RESERVED, 1'b0);
    chk("lowp", 16'h0000, 16'(lowp));
  endtask
  initial
  begin
    rstn = 1'b0;
    pcs = 1'b0;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (2) @(posedge mclk);
    #1;
    rstn = 1'b1;
    i_ddr_ctrl_model.issue(4'h8, 1'b1, 3'h0, 16'h0);
    t_mode();
    t_rows();
    t_burst();
    t_power();
    rstn = 1'b0;
    #3;
    chk("code", 16'h0000, 16'(code));
    test_done();
  end
endmodule // sdram_command_decoder_bench
